// ===== rtl/usb_irq_pkg.sv
// Constants and carrier types for the frame number and interrupt flag block.
// Assumes one 200 MHz clock and an APB register port with 32-bit data.
// How it works
// - Frame number low register shows bits 7..0 of last frame, read-only.
// - Frame number high register bits 2..0 show frame bits 10..8.
// - Frame number high bits 7..3 read zero; writes ignored.
// - Interrupt request is high the cycle after any pending flag whose enable bit is set is one.
// - Reading a flag register returns flags then clears all but any set on the same edge.
// - Flag registers are read-only; enables live in separate registers.
// - IN flag register: endpoints 3..1 in bits 3..1, control endpoint bit 0.
// - OUT flag register: endpoints 3..1 in bits 3..1; one means pending.
// - Upper four bits of both endpoint flag registers read zero.
// - OUT flag register bit 0 is unused, reads zero, ignores writes.
// - Common flags set start-of-frame on token or on a missed frame.
// - Common flags set bus reset, resume in suspend, suspend when enabled.
// - IN endpoint enables for endpoints 0..3 come up set after reset.
package usb_irq_pkg;
  // Register indices, decoded from paddr[5:2] (printed offsets are register indices)
  localparam logic [3:0] IDX_IN_FLAGS = 4'h2;
  localparam logic [3:0] IDX_OUT_FLAGS = 4'h4;
  localparam logic [3:0] IDX_COMMON_FLAGS = 4'h6;
  localparam logic [3:0] IDX_IN_ENABLE = 4'h7;
  localparam logic [3:0] IDX_OUT_ENABLE = 4'h9;
  localparam logic [3:0] IDX_COMMON_ENABLE = 4'hB;
  localparam logic [3:0] IDX_FRAME_LOW = 4'hC;
  localparam logic [3:0] IDX_FRAME_HIGH = 4'hD;
  localparam logic [3:0] IDX_POWER_CTRL = 4'h1;
  // Reset values
  localparam logic [3:0] IN_ENABLE_RESET = 4'hF;
  localparam logic [3:0] OUT_ENABLE_RESET = 4'hE;
  localparam logic [3:0] COMMON_ENABLE_RESET = 4'h6;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [10:0] FRAME_RESET = 11'h000;
  // Common flag field positions
  localparam int COMMON_SUSPEND_BIT = 0;
  localparam int COMMON_RESUME_BIT = 1;
  localparam int COMMON_RESET_BIT = 2;
  localparam int COMMON_SOF_BIT = 3;
  // Frame period and watchdog slack for a synthesized start of frame
  localparam int FRAME_PERIOD_MS = 1;
  localparam int CLK_MHZ = 200;
  localparam int SOF_SLACK_CYCLES = 20;
  localparam int SOF_TIMEOUT_CYCLES =
    FRAME_PERIOD_MS * 1000 * CLK_MHZ + SOF_SLACK_CYCLES;
  localparam int SOF_CNT_W = 18;
  localparam int FLAG_W = 4;

  // Events reported by the USB core, one-cycle pulses
  typedef struct packed {
    logic [3:0] in_done;
    logic [3:0] out_done;
    logic sof_token;
    logic [10:0] frame;
    logic bus_reset;
    logic resume;
    logic suspend;
  } usb_events_t;
endpackage : usb_irq_pkg

// ===== rtl/flag_bank.sv
// Read-to-clear bank of pending flags with a per-bit valid mask.
// Assumes set pulses and the clearing read come from the clk domain.
`timescale 1ns/1ps
module flag_bank #(
  parameter logic [3:0] VALID = 4'hF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Events and clear
  input wire logic [3:0] set,
  input wire logic clear,
  // Flags
  output logic [3:0] flags
);
  // One flop per flag, set wins over a clearing read
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_flag
      if (VALID[i])
      begin : g_used
        always_ff @(posedge clk)
        begin
          if (!nrst)
            flags[i] <= 1'b0;
          else if (set[i])
            flags[i] <= 1'b1;
          else if (clear)
            flags[i] <= 1'b0;
        end
        a_set_wins: assert property (@(posedge clk) disable iff (!nrst)
          set[i] |=> flags[i]) else $error("flag lost on set");
        a_read_clears: assert property (@(posedge clk) disable iff (!nrst)
          clear && !set[i] |=> !flags[i]) else $error("no clear");
      end
      else
      begin : g_unused
        assign flags[i] = 1'b0;
      end
    end
  endgenerate
endmodule : flag_bank

// ===== rtl/sof_watch.sv
// Start-of-frame watchdog: pulses when a frame token arrives or is overdue.
// Assumes sof_token is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
module sof_watch #(
  parameter int TIMEOUT = usb_irq_pkg::SOF_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Token in, frame event out
  input wire logic sof_token,
  input wire logic armed,
  output logic sof_event
);
  logic [usb_irq_pkg::SOF_CNT_W-1:0] count;
  logic overdue;

  assign overdue = armed &&
    (count == usb_irq_pkg::SOF_CNT_W'(TIMEOUT - 1));

  // Counter restarts on each real or synthesized frame
  always_ff @(posedge clk)
  begin
    if (!nrst || sof_token || overdue || !armed)
      count <= '0;
    else
      count <= count + 1'b1;
  end

  // Frame event fires for real token or a missed one
  always_ff @(posedge clk)
  begin
    if (!nrst)
      sof_event <= 1'b0;
    else
      sof_event <= sof_token || overdue;
  end

  a_sof_event: assert property (@(posedge clk) disable iff (!nrst)
    sof_token |=> sof_event) else $error("frame event missing");
  a_sof_synth: assert property (@(posedge clk) disable iff (!nrst)
    overdue |=> sof_event) else $error("missed frame not synthesized");
  a_count_idle: assert property (@(posedge clk) disable iff (!nrst)
    !armed |=> count == '0) else $error("watchdog ran while idle");
endmodule : sof_watch

// ===== rtl/usb_frame_irq.sv
// Frame number registers, endpoint and common interrupt flags, APB slave.
// Assumes events from the USB core arrive as one-cycle pulses on clk.
`timescale 1ns/1ps
module usb_frame_irq (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events from the USB core
  input wire usb_irq_pkg::usb_events_t events,
  // Interrupt request to the system interrupt enable
  output logic usb_irq
);
  logic [10:0] frame;
  logic [3:0] in_flags;
  logic [3:0] out_flags;
  logic [3:0] common_flags;
  logic [3:0] in_enable;
  logic [3:0] out_enable;
  logic [3:0] common_enable;
  logic suspend_detect_enable;
  logic suspended;
  logic sof_event;
  logic setup;
  logic wr_now;
  logic rd_now;
  logic aligned;
  logic [3:0] index;
  logic [7:0] next_rdata;
  logic mapped;
  logic clr_in;
  logic clr_out;
  logic clr_common;
  logic [3:0] common_set;
  logic next_irq;
  logic frames_started;
  logic watch_armed;

  // APB decode; every access completes in one access cycle
  assign setup = psel && !penable;
  assign aligned = (paddr[1:0] == 2'b00);
  assign index = paddr[5:2];
  assign wr_now = psel && penable && pready && pwrite;
  // Reads capture data and clear flags at the same setup edge, so an
  // event landing between capture and clear can never be lost
  assign rd_now = setup && !pwrite && aligned;
  assign clr_in = rd_now && index == usb_irq_pkg::IDX_IN_FLAGS;
  assign clr_out = rd_now && index == usb_irq_pkg::IDX_OUT_FLAGS;
  assign clr_common = rd_now && index == usb_irq_pkg::IDX_COMMON_FLAGS;

  // Ready rises one cycle after setup, so access lasts one cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  // Latched frame number from each received start-of-frame token
  always_ff @(posedge clk)
  begin
    if (!nrst)
      frame <= usb_irq_pkg::FRAME_RESET;
    else if (events.sof_token)
      frame <= events.frame;
  end

  // Suspend state follows core suspend and resume signalling
  always_ff @(posedge clk)
  begin
    if (!nrst)
      suspended <= 1'b0;
    else if (events.resume || events.bus_reset)
      suspended <= 1'b0;
    else if (events.suspend && suspend_detect_enable)
      suspended <= 1'b1;
  end

  // Common flag set terms
  always_comb
  begin
    common_set = 4'h0;
    common_set[usb_irq_pkg::COMMON_SOF_BIT] = sof_event;
    common_set[usb_irq_pkg::COMMON_RESET_BIT] = events.bus_reset;
    common_set[usb_irq_pkg::COMMON_RESUME_BIT] =
      events.resume && suspended;
    common_set[usb_irq_pkg::COMMON_SUSPEND_BIT] =
      events.suspend && suspend_detect_enable;
  end

  // Watchdog arms after the first real token, disarms on bus reset
  always_ff @(posedge clk)
  begin
    if (!nrst || events.bus_reset)
      frames_started <= 1'b0;
    else if (events.sof_token)
      frames_started <= 1'b1;
  end

  // No frames are expected while suspended
  assign watch_armed = frames_started && !suspended;

  // Missed frame tokens are synthesized once frames have started
  sof_watch u_sof (
    .clk(clk),
    .nrst(nrst),
    .sof_token(events.sof_token),
    .armed(watch_armed),
    .sof_event(sof_event)
  );

  // IN endpoint flags, all four bits live
  flag_bank #(.VALID(4'hF)) u_in (
    .clk(clk),
    .nrst(nrst),
    .set(events.in_done),
    .clear(clr_in),
    .flags(in_flags)
  );

  // OUT endpoint flags, bit zero unused
  flag_bank #(.VALID(4'hE)) u_out (
    .clk(clk),
    .nrst(nrst),
    .set(events.out_done),
    .clear(clr_out),
    .flags(out_flags)
  );

  // Common flags
  flag_bank #(.VALID(4'hF)) u_common (
    .clk(clk),
    .nrst(nrst),
    .set(common_set),
    .clear(clr_common),
    .flags(common_flags)
  );

  // Enable registers, written by software; flag registers ignore writes
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      in_enable <= usb_irq_pkg::IN_ENABLE_RESET;
      out_enable <= usb_irq_pkg::OUT_ENABLE_RESET;
      common_enable <= usb_irq_pkg::COMMON_ENABLE_RESET;
      suspend_detect_enable <= 1'b0;
    end
    else if (wr_now && aligned)
    begin
      unique case (index)
        usb_irq_pkg::IDX_IN_ENABLE: in_enable <= pwdata[3:0];
        usb_irq_pkg::IDX_OUT_ENABLE: out_enable <= {pwdata[3:1], 1'b0};
        usb_irq_pkg::IDX_COMMON_ENABLE: common_enable <= pwdata[3:0];
        usb_irq_pkg::IDX_POWER_CTRL: suspend_detect_enable <= pwdata[0];
        default: ;
      endcase
    end
  end

  // Read mux; upper bits zero in every register
  always_comb
  begin
    next_rdata = 8'h00;
    mapped = aligned;
    unique case (index)
      usb_irq_pkg::IDX_IN_FLAGS: next_rdata = {4'h0, in_flags};
      usb_irq_pkg::IDX_OUT_FLAGS:
        next_rdata = {4'h0, out_flags[3:1], 1'b0};
      usb_irq_pkg::IDX_COMMON_FLAGS: next_rdata = {4'h0, common_flags};
      usb_irq_pkg::IDX_IN_ENABLE: next_rdata = {4'h0, in_enable};
      usb_irq_pkg::IDX_OUT_ENABLE: next_rdata = {4'h0, out_enable};
      usb_irq_pkg::IDX_COMMON_ENABLE: next_rdata = {4'h0, common_enable};
      usb_irq_pkg::IDX_POWER_CTRL:
        next_rdata = {6'h00, suspended, suspend_detect_enable};
      usb_irq_pkg::IDX_FRAME_LOW: next_rdata = frame[7:0];
      usb_irq_pkg::IDX_FRAME_HIGH:
        next_rdata = {5'h00, frame[10:8]};
      default: mapped = 1'b0;
    endcase
  end

  // Read data and error captured in the setup cycle, stable in access
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
      pslverr <= !mapped;
    end
  end

  // Any pending and enabled flag raises the request
  assign next_irq = |(in_flags & in_enable) | |(out_flags & out_enable) |
    |(common_flags & common_enable);

  always_ff @(posedge clk)
  begin
    if (!nrst)
      usb_irq <= 1'b0;
    else
      usb_irq <= next_irq;
  end

  // Checks
  sequence s_access;
    psel && penable && pready;
  endsequence

  sequence s_setup;
    psel && !penable;
  endsequence

  a_irq_follows: assert property (@(posedge clk) disable iff (!nrst)
    next_irq |=> usb_irq) else $error("irq not raised");
  a_frame_high_zero: assert property (@(posedge clk) disable iff (!nrst)
    s_setup ##0 (!pwrite && aligned &&
    index == usb_irq_pkg::IDX_FRAME_HIGH) |=> prdata[31:3] == 29'h0)
    else $error("upper bits set");
  a_frame_low: assert property (@(posedge clk) disable iff (!nrst)
    events.sof_token |=> frame == $past(events.frame))
    else $error("frame not latched");
  a_in_clear: assert property (@(posedge clk) disable iff (!nrst)
    s_setup ##0 (clr_in && events.in_done == 4'h0) |=> in_flags == 4'h0)
    else $error("in flags kept");
  a_out_clear: assert property (@(posedge clk) disable iff (!nrst)
    s_setup ##0 (clr_out && events.out_done == 4'h0) |=> out_flags == 4'h0)
    else $error("out flags kept");
  a_out_bit0: assert property (@(posedge clk) disable iff (!nrst)
    !out_flags[0]) else $error("out bit0 set");
  a_enable_reset: assert property (@(posedge clk)
    !nrst |=> in_enable == 4'hF) else $error("enable reset");
  a_flags_readonly: assert property (@(posedge clk) disable iff (!nrst)
    wr_now && index == usb_irq_pkg::IDX_IN_FLAGS && events.in_done == 4'h0
    |=> in_flags == $past(in_flags)) else $error("flag written");
  a_resume_only: assert property (@(posedge clk) disable iff (!nrst)
    events.resume && !suspended && !clr_common &&
    !common_flags[usb_irq_pkg::COMMON_RESUME_BIT]
    |=> !common_flags[usb_irq_pkg::COMMON_RESUME_BIT])
    else $error("resume outside suspend");
  a_ready_one: assert property (@(posedge clk) disable iff (!nrst)
    psel && !penable |=> pready) else $error("late ready");
  a_ready_drop: assert property (@(posedge clk) disable iff (!nrst)
    s_access |=> !pready) else $error("ready held");
  a_irq_drops: assert property (@(posedge clk) disable iff (!nrst)
    !next_irq |=> !usb_irq) else $error("irq stuck");
  a_sof_flag: assert property (@(posedge clk) disable iff (!nrst)
    sof_event |=> common_flags[usb_irq_pkg::COMMON_SOF_BIT])
    else $error("sof flag missing");
  a_reset_flag: assert property (@(posedge clk) disable iff (!nrst)
    events.bus_reset |=> common_flags[usb_irq_pkg::COMMON_RESET_BIT])
    else $error("reset flag missing");
  a_in_layout: assert property (@(posedge clk) disable iff (!nrst)
    s_setup ##0 (!pwrite && aligned && index == usb_irq_pkg::IDX_IN_FLAGS)
    |=> prdata == {28'h000_0000, $past(in_flags)})
    else $error("in flags read wrong");
  a_out_layout: assert property (@(posedge clk) disable iff (!nrst)
    s_setup ##0 (!pwrite && aligned && index == usb_irq_pkg::IDX_OUT_FLAGS)
    |=> prdata[31:4] == 28'h000_0000 && !prdata[0])
    else $error("out flags read wrong");
endmodule : usb_frame_irq

// ===== testbench/usb_host_model.sv
// Model of the USB core side: one-cycle event pulses for tokens and frames.
// Assumes the bench calls send from clk-synchronous code.
`timescale 1ns/1ps
module usb_host_model (
  // Clock
  input wire logic clk,
  // Events toward the block
  output usb_irq_pkg::usb_events_t ev
);
  initial ev = '0;

  // Pulse for one cycle, then the frame field shows junk, not the last value
  task send(input usb_irq_pkg::usb_events_t e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '{frame: ~e.frame, default: '0};
  endtask : send
endmodule : usb_host_model

// ===== testbench/usb_frame_irq_bench.sv
// Self-checking bench for the frame number and interrupt flag block.
// Assumes a 200 MHz clock and the USB core model for event pulses.
`timescale 1ns/1ps
module usb_frame_irq_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [5:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic usb_irq;
  logic [31:0] rd;
  logic err;
  logic [10:0] f;
  usb_irq_pkg::usb_events_t events;
  usb_irq_pkg::usb_events_t e;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Clock, 5 ns period
  always #2.5 clk = ~clk;

  usb_frame_irq usb_frame_irq_i (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events(events), .usb_irq(usb_irq));
  usb_host_model usb_host_model_i (.clk(clk), .ev(events));

  // Verdict and end of run
  task test_done;
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // Compare a value with its expectation
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  // One APB transfer; waits for pready, takes data at that edge
  task apb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Read a register and compare
  task rchk(input string n, input logic [5:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, rd);
  endtask : rchk

  // Send a core event from a clean struct
  task fire(input usb_irq_pkg::usb_events_t v);
    usb_host_model_i.send(v);
  endtask : fire

  // Reset values and an unmapped access
  task t_reset;
    rchk("in flags", 6'h08, 32'h0);
    rchk("out flags", 6'h10, 32'h0);
    rchk("frame low", 6'h30, 32'h0);
    rchk("frame high", 6'h34, 32'h0);
    rchk("in enable", 6'h1C, 32'h0000000F);
    apb(1'b0, 6'h3C, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
  endtask : t_reset

  // Frame numbers incl. all-ones; writes to frame registers ignored
  task t_frame;
    for (int i = 0; i < 3; i++)
    begin
      f = (i == 0) ? 11'h5A5 : (i == 1) ? 11'h7FF : 11'h100;
      e = '0;
      e.sof_token = 1'b1;
      e.frame = f;
      fire(e);
      apb(1'b1, 6'h34, 32'hFF);
      apb(1'b1, 6'h30, 32'h0);
      rchk("frame low", 6'h30, {24'h0, f[7:0]});
      rchk("frame high", 6'h34, {29'h0, f[10:8]});
      rchk("common sof", 6'h18, 32'h8);
    end
  endtask : t_frame

  // Endpoint flags: irq, layout, clearing read, ignored writes
  task t_endpoints;
    e = '0;
    e.in_done = 4'hF;
    fire(e);
    repeat (3) @(posedge clk);
    chk("irq set", 32'h1, {31'h0, usb_irq});
    apb(1'b1, 6'h08, 32'hFF);
    rchk("in flags", 6'h08, 32'hF);
    rchk("in flags cleared", 6'h08, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, usb_irq});
    e = '0;
    e.out_done = 4'hF;
    fire(e);
    rchk("out flags", 6'h10, 32'hE);
    rchk("out flags cleared", 6'h10, 32'h0);
  endtask : t_endpoints

  // Event lands on the edge of the clearing read
  task t_race;
    e = '0;
    e.in_done = 4'h1;
    fire(e);
    fork
      apb(1'b0, 6'h08, 32'h0);
      begin
        e.in_done = 4'h2;
        fire(e);
      end
    join
    chk("in flags race", 32'h1, rd);
    rchk("in flags kept", 6'h08, 32'h2);
  endtask : t_race

  // Bus reset, suspend gated by detect enable, resume in suspend
  task t_common;
    e = '0;
    e.bus_reset = 1'b1;
    fire(e);
    rchk("common reset", 6'h18, 32'h4);
    e = '0;
    e.suspend = 1'b1;
    fire(e);
    rchk("suspend off", 6'h18, 32'h0);
    apb(1'b1, 6'h04, 32'h1);
    fire(e);
    rchk("suspend on", 6'h18, 32'h1);
    e = '0;
    e.resume = 1'b1;
    fire(e);
    rchk("resume", 6'h18, 32'h2);
  endtask : t_common

  // Cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      test_done;
    end
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_frame;
    t_endpoints;
    t_race;
    t_common;
    test_done;
  end
endmodule : usb_frame_irq_bench
